// *** pwmcc_channel.sv ***
// One PWM channel: counter, waveform and period-start buffering
`timescale 1ns/100ps
`default_nettype none
`include "pwmcc_params.svh"
module pwmcc_channel
	import pwmcc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration
	input wire pwmcc_cfg_t cfg,
	input wire logic enable,
	input wire logic tick,
	input wire logic upd_we,
	input wire logic [15:0] upd_val,
	// Status
	output logic [15:0] count,
	output logic [15:0] act_duty,
	output logic [15:0] act_period,
	output logic wave,
	output logic period_done
);
	logic down;
	logic upd_pend;
	logic [15:0] upd_hold;
	logic upd_tgt;
	logic at_start;

	// ==========================================================
	// Counter: left runs 0..period-1, center runs up then down
	assign at_start = tick && ((cfg.mode.align == 1'b0) ?
		(count + 16'h0001 >= act_period) : (down && count <= 16'h0001));

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			count <= `PWMCC_RST_CNT;
			down <= 1'b0;
			period_done <= 1'b0;
		end else begin
			period_done <= at_start;
			if (tick) begin
				if (cfg.mode.align == 1'b0) begin
					count <= at_start ? 16'h0000 : count + 16'h0001;
				end else if (!down) begin
					if (count + 16'h0001 >= act_period) begin
						down <= 1'b1;
					end
					count <= (count + 16'h0001 >= act_period) ? act_period : count + 16'h0001;
				end else begin
					if (at_start) begin
						down <= 1'b0;
					end
					count <= (count == 16'h0000) ? 16'h0000 : count - 16'h0001;
				end
			end
		end
	end

	// ==========================================================
	// Update buffering: new value applies at the next period start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upd_pend <= 1'b0;
			upd_hold <= 16'h0000;
			upd_tgt <= 1'b0;
		end else if (upd_we) begin
			upd_pend <= 1'b1;
			upd_hold <= upd_val;
			upd_tgt <= cfg.mode.target;
		end else if (at_start || !enable) begin
			upd_pend <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_duty <= 16'h0000;
			act_period <= 16'h0000;
		end else if (!enable || (at_start && !upd_pend)) begin
			act_duty <= cfg.duty;
			act_period <= cfg.period;
		end else if (at_start && upd_pend) begin
			if (upd_tgt) begin
				act_period <= upd_hold;
			end else begin
				act_duty <= upd_hold;
			end
		end
	end

	// ==========================================================
	// Waveform: start level held until the counter reaches the duty value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wave <= 1'b0;
		end else begin
			wave <= (count < act_duty) ? cfg.mode.level : ~cfg.mode.level;
		end
	end
endmodule : pwmcc_channel
`default_nettype wire

// *** pwmcc_params.svh ***
// Register map, field positions and reset values of the PWM channel block
`ifndef PWMCC_PARAMS_SVH
`define PWMCC_PARAMS_SVH

// ==========================================================
// Register offsets
`define PWMCC_MODE_OFS 12'h000
`define PWMCC_IER_OFS 12'h010
`define PWMCC_IDR_OFS 12'h014
`define PWMCC_IMR_OFS 12'h018
`define PWMCC_ISR_OFS 12'h01C
`define PWMCC_CH_BASE 12'h200
`define PWMCC_CH_STRIDE_BIT 5
`define PWMCC_CMR_SUB 5'h00
`define PWMCC_DUTY_VALUE_SUB 5'h04
`define PWMCC_PERIOD_VALUE_SUB 5'h08
`define PWMCC_CCNT_SUB 5'h0C
`define PWMCC_CUPD_SUB 5'h10

// ==========================================================
// Field positions
`define PWMCC_DIVIDER_FACTOR_A_LSB 0
`define PWMCC_PREA_LSB 8
`define PWMCC_DIVB_LSB 16
`define PWMCC_PREB_LSB 24
`define PWMCC_ALIGN_BIT 8
`define PWMCC_LEVEL_BIT 9
`define PWMCC_TARGET_BIT 10
`define PWMCC_CODE_DIVIDER_CLOCK_A 4'hB
`define PWMCC_CODE_DIVIDER_CLOCK_B 4'hC
`define PWMCC_CODE_MAXDIV 4'hA

// ==========================================================
// Reset values
`define PWMCC_RST_WORD 32'h0000_0000
`define PWMCC_RST_CNT 16'h0000

`endif

// *** pwmcc_pkg.sv ***
// Types shared by the PWM channel block
package pwmcc_pkg;
	typedef struct packed {
		logic target;
		logic level;
		logic align;
		logic [3:0] presc;
	} pwmcc_mode_t;

	typedef struct packed {
		logic [15:0] duty;
		logic [15:0] period;
		pwmcc_mode_t mode;
	} pwmcc_cfg_t;

	typedef enum logic [1:0] {
		PWMCC_IDLE = 2'b00,
		PWMCC_RESP = 2'b01
	} pwmcc_bus_t;
endpackage : pwmcc_pkg

// *** pwmcc_properties.sv ***
// Bus and interrupt-mask checks of the PWM channel block
`timescale 1ns/100ps
`default_nettype none
`include "pwmcc_params.svh"
// ==========
// Checker
module pwmcc_properties (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write side
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	// Read side
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	input wire logic irq
);
	localparam logic [11:0] IER = `PWMCC_IER_OFS;
	localparam logic [11:0] IDR = `PWMCC_IDR_OFS;
	localparam logic [11:0] IMR = `PWMCC_IMR_OFS;
	logic [11:0] wa;
	logic [11:0] ra;
	logic [31:0] wd;
	logic [3:0] mask;
	logic [3:0] eff;
	logic bv_q;
	logic done;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Shadow enables move with the response, when the write lands in the block
	assign done = s_axi_bvalid && !bv_q;
	always_comb begin
		eff = mask;
		if (done && wa[11:2] == IER[11:2]) eff = mask | wd[3:0];
		if (done && wa[11:2] == IDR[11:2]) eff = mask & ~wd[3:0];
	end
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
		if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
	end
	always_ff @(posedge aclk) begin
		bv_q <= aresetn && s_axi_bvalid;
		mask <= aresetn ? eff : 4'h0;
	end
	AST_B_AFTER_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	AST_BRESP_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data not held");
	AST_MASK_READ: assert property (
		s_axi_rvalid && ra[11:2] == IMR[11:2] |-> s_axi_rdata == {28'h0000000, mask})
		else $error("mask readback wrong");
	AST_IRQ_MASKED: assert property (eff == 4'h0 |-> !irq)
		else $error("irq with all channels masked");
	AST_IDR_ALL: assert property (
		done && wa[11:2] == IDR[11:2] && wd[3:0] == 4'hF |-> !irq)
		else $error("irq after disabling all");
	AST_UNMAPPED: assert property (s_axi_rvalid && ra[11:8] == 4'h1
		|-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule : pwmcc_properties

bind pwmcc_top pwmcc_properties u_props (.*);
`default_nettype wire

// *** pwmcc_top.sv ***
// PWM channel configuration, prescaling and interrupt bookkeeping, AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "pwmcc_params.svh"
// Summary of operation
// - Disable write of one clears channel enable
// - Mask register reads back interrupt enables
// - Period completion sets sticky status flag
// - Status read returns flags then clears them
// - Codes 0..10 divide master clock by 2^code
// - Codes 11, 12 pick divider clocks A, B
// - Alignment bit selects left or center period
// - Level bit sets waveform starting level
// - Update target 0 loads duty at start
// - Update target 1 loads period at start
// - Only low 16 duty bits drive waveform
// - Enable write of one sets channel enable
// - Factor zero stops divider clock, one passes
module pwmcc_top
	import pwmcc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Outputs
	output logic [3:0] pwm_out,
	output logic irq
);
	localparam int NCH = 4;

	logic [31:0] mode_word;
	logic [3:0] ch_enable;
	logic [3:0] irq_mask;
	logic [3:0] irq_status;
	logic [31:0] ch_mode [NCH];
	logic [31:0] ch_duty [NCH];
	logic [31:0] ch_period [NCH];
	logic [15:0] ch_count [NCH];
	logic [3:0] ch_done;
	logic [3:0] ch_tick;
	logic [11:0] aw_hold;
	logic [31:0] w_hold;
	logic aw_have;
	logic w_have;
	logic do_write;
	logic do_read;
	logic [31:0] next_rdata;
	logic rd_ok;
	logic [10:0] presc_cnt;
	logic [10:0] presc_prev;
	logic [12:0] presc_tick;
	logic [7:0] div_a_cnt;
	logic [7:0] div_b_cnt;
	logic clk_a_tick;
	logic clk_b_tick;

	// ==========================================================
	// Register decode helpers
	function automatic logic is_ch(input logic [11:0] a, input int ch, input logic [4:0] sub);
		return a == (`PWMCC_CH_BASE | 12'(ch << `PWMCC_CH_STRIDE_BIT) | {7'h00, sub});
	endfunction : is_ch

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : apply_strb

	// ==========================================================
	// AXI4-Lite write path: address and data accepted in either order
	assign s_axi_awready = !aw_have && !s_axi_bvalid;
	assign s_axi_wready = !w_have && !s_axi_bvalid;
	assign do_write = aw_have && w_have && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_hold <= 12'h000;
			w_hold <= `PWMCC_RST_WORD;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_hold <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_hold <= apply_strb(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
			end
			if (do_write) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_bresp = 2'b00;

	// ==========================================================
	// Global mode word, channel enables and interrupt enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_word <= `PWMCC_RST_WORD;
			ch_enable <= 4'h0;
			irq_mask <= 4'h0;
		end else if (do_write) begin
			case (aw_hold)
				`PWMCC_MODE_OFS: mode_word <= w_hold;
				12'h004: ch_enable <= ch_enable | w_hold[3:0];
				12'h008: ch_enable <= ch_enable & ~w_hold[3:0];
				`PWMCC_IER_OFS: irq_mask <= irq_mask | w_hold[3:0];
				`PWMCC_IDR_OFS: irq_mask <= irq_mask & ~w_hold[3:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Channel registers; partial byte writes clear the unwritten bytes
	for (genvar c = 0; c < NCH; c++) begin : g_reg
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ch_mode[c] <= `PWMCC_RST_WORD;
				ch_duty[c] <= `PWMCC_RST_WORD;
				ch_period[c] <= `PWMCC_RST_WORD;
			end else if (do_write) begin
				if (is_ch(aw_hold, c, `PWMCC_CMR_SUB)) begin
					ch_mode[c] <= w_hold & 32'h0000_070F;
				end
				if (is_ch(aw_hold, c, `PWMCC_DUTY_VALUE_SUB)) begin
					ch_duty[c] <= w_hold;
				end
				if (is_ch(aw_hold, c, `PWMCC_PERIOD_VALUE_SUB)) begin
					ch_period[c] <= w_hold;
				end
				// Update rewrites its target too, so later period starts keep the value
				if (is_ch(aw_hold, c, `PWMCC_CUPD_SUB) && ch_mode[c][`PWMCC_TARGET_BIT]) begin
					ch_period[c] <= w_hold;
				end
				if (is_ch(aw_hold, c, `PWMCC_CUPD_SUB) && !ch_mode[c][`PWMCC_TARGET_BIT]) begin
					ch_duty[c] <= w_hold;
				end
			end
		end
	end

	// ==========================================================
	// Prescaler: one master-clock-wide tick per power-of-two division
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_cnt <= 11'h000;
			presc_prev <= 11'h000;
		end else begin
			presc_prev <= presc_cnt;
			presc_cnt <= presc_cnt + 11'h001;
		end
	end

	always_comb begin
		presc_tick[0] = 1'b1;
		for (int k = 1; k <= 10; k++) begin
			presc_tick[k] = presc_cnt[k-1] == 1'b0 && presc_prev[k-1] == 1'b1;
		end
		presc_tick[11] = clk_a_tick;
		presc_tick[12] = clk_b_tick;
	end

	// ==========================================================
	// Divider clocks A and B; zero stops, one passes through
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_a_cnt <= 8'h00;
			div_b_cnt <= 8'h00;
			clk_a_tick <= 1'b0;
			clk_b_tick <= 1'b0;
		end else begin
			clk_a_tick <= 1'b0;
			clk_b_tick <= 1'b0;
			if (mode_word[`PWMCC_DIVIDER_FACTOR_A_LSB +: 8] == 8'h00) begin
				div_a_cnt <= 8'h00;
			end else if (presc_tick[mode_word[`PWMCC_PREA_LSB +: 4] > 4'hA ?
				4'h0 : mode_word[`PWMCC_PREA_LSB +: 4]]) begin
				div_a_cnt <= (div_a_cnt + 8'h01 >= mode_word[`PWMCC_DIVIDER_FACTOR_A_LSB +: 8]) ?
					8'h00 : div_a_cnt + 8'h01;
				clk_a_tick <= div_a_cnt + 8'h01 >= mode_word[`PWMCC_DIVIDER_FACTOR_A_LSB +: 8];
			end
			if (mode_word[`PWMCC_DIVB_LSB +: 8] == 8'h00) begin
				div_b_cnt <= 8'h00;
			end else if (presc_tick[mode_word[`PWMCC_PREB_LSB +: 4] > 4'hA ?
				4'h0 : mode_word[`PWMCC_PREB_LSB +: 4]]) begin
				div_b_cnt <= (div_b_cnt + 8'h01 >= mode_word[`PWMCC_DIVB_LSB +: 8]) ?
					8'h00 : div_b_cnt + 8'h01;
				clk_b_tick <= div_b_cnt + 8'h01 >= mode_word[`PWMCC_DIVB_LSB +: 8];
			end
		end
	end

	// ==========================================================
	// Channels; reserved prescaler codes never tick
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		wire pwmcc_cfg_t cfg;
		assign cfg.duty = ch_duty[c][15:0];
		assign cfg.period = ch_period[c][15:0];
		assign cfg.mode.target = ch_mode[c][`PWMCC_TARGET_BIT];
		assign cfg.mode.level = ch_mode[c][`PWMCC_LEVEL_BIT];
		assign cfg.mode.align = ch_mode[c][`PWMCC_ALIGN_BIT];
		assign cfg.mode.presc = ch_mode[c][3:0];
		assign ch_tick[c] = (cfg.mode.presc <= `PWMCC_CODE_DIVIDER_CLOCK_B) ?
			presc_tick[cfg.mode.presc] : 1'b0;

		pwmcc_channel u_ch (
			.aclk(aclk),
			.aresetn(aresetn),
			.cfg(cfg),
			.enable(ch_enable[c]),
			.tick(ch_tick[c]),
			.upd_we(do_write && is_ch(aw_hold, c, `PWMCC_CUPD_SUB)),
			.upd_val(w_hold[15:0]),
			.count(ch_count[c]),
			.act_duty(),
			.act_period(),
			.wave(pwm_out[c]),
			.period_done(ch_done[c])
		);
	end

	// ==========================================================
	// AXI4-Lite read path, one cycle to rvalid
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	always_comb begin
		next_rdata = 32'h0000_0000;
		rd_ok = 1'b1;
		case ({s_axi_araddr[11:2], 2'b00})
			`PWMCC_MODE_OFS: next_rdata = mode_word;
			12'h00C: next_rdata = {28'h0000000, ch_enable};
			`PWMCC_IMR_OFS: next_rdata = {28'h0000000, irq_mask};
			`PWMCC_ISR_OFS: next_rdata = {28'h0000000, irq_status};
			12'h004, 12'h008, `PWMCC_IER_OFS, `PWMCC_IDR_OFS: next_rdata = 32'h0000_0000;
			default: rd_ok = 1'b0;
		endcase
		for (int c = 0; c < NCH; c++) begin
			if (is_ch({s_axi_araddr[11:2], 2'b00}, c, `PWMCC_CMR_SUB)) begin
				next_rdata = ch_mode[c];
				rd_ok = 1'b1;
			end
			if (is_ch({s_axi_araddr[11:2], 2'b00}, c, `PWMCC_DUTY_VALUE_SUB)) begin
				next_rdata = ch_duty[c];
				rd_ok = 1'b1;
			end
			if (is_ch({s_axi_araddr[11:2], 2'b00}, c, `PWMCC_PERIOD_VALUE_SUB)) begin
				next_rdata = ch_period[c];
				rd_ok = 1'b1;
			end
			if (is_ch({s_axi_araddr[11:2], 2'b00}, c, `PWMCC_CCNT_SUB)) begin
				next_rdata = {16'h0000, ch_count[c]};
				rd_ok = 1'b1;
			end
			if (is_ch({s_axi_araddr[11:2], 2'b00}, c, `PWMCC_CUPD_SUB)) begin
				next_rdata = 32'h0000_0000;
				rd_ok = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `PWMCC_RST_WORD;
			s_axi_rresp <= 2'b00;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Period flags: a completion in the read cycle survives the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= 4'h0;
		end else if (do_read && {s_axi_araddr[11:2], 2'b00} == `PWMCC_ISR_OFS) begin
			irq_status <= ch_done;
		end else begin
			irq_status <= irq_status | ch_done;
		end
	end

	assign irq = |(irq_status & irq_mask);
endmodule : pwmcc_top
`default_nettype wire

// *** pwmcc_top_tb.sv ***
// Self-checking bench of the PWM channel block
`timescale 1ns/100ps
`default_nettype none
`include "pwmcc_params.svh"
module pwmcc_top_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_bvalid;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_arready;
	logic s_axi_rvalid, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, pwm_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	int n_errors, samples_checked, per, hi;
	pwmcc_top u_dut (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// ==========
	// Bus and compare tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	function automatic logic [11:0] ca(input int c, input logic [4:0] s);
		return `PWMCC_CH_BASE + 12'(c * 32) + {7'h00, s};
	endfunction : ca
	// Channel is stopped first so that duty and period load directly
	task automatic cfg(input int c, input logic [31:0] md, input logic [31:0] dt,
		input logic [31:0] pr);
		wr(12'h008, 32'h1 << c);
		wr(ca(c, `PWMCC_CMR_SUB), md);
		wr(ca(c, `PWMCC_DUTY_VALUE_SUB), dt);
		wr(ca(c, `PWMCC_PERIOD_VALUE_SUB), pr);
		wr(12'h004, 32'h1 << c);
	endtask : cfg
	// Skips two rising edges so a pending update has landed
	task automatic meas(input int c);
		logic p;
		int k;
		p = 1'b1;
		k = 0;
		per = 0;
		hi = 0;
		while (k < 3) begin
			@(posedge aclk);
			if (k == 2) begin
				per++;
				hi += int'(pwm_out[c]);
			end
			if (pwm_out[c] === 1'b1 && p !== 1'b1) k++;
			p = pwm_out[c];
		end
	endtask : meas
	task automatic hold(input int c, input logic v);
		int bad;
		bad = 0;
		repeat (5) @(posedge aclk);
		repeat (60) begin
			@(posedge aclk);
			if (pwm_out[c] !== v) bad++;
		end
		chk(32'(bad), 32'h0, "level");
	endtask : hold
	task automatic run(input logic [31:0] gm, input logic [3:0] code, input int u);
		wr(`PWMCC_MODE_OFS, gm);
		cfg(1, 32'(code), 32'h1, 32'h2);
		meas(1);
		chk(32'(per), 32'(2 * u), "period");
		chk(32'(hi), 32'(u), "high time");
	endtask : run
	// ==========
	// Scenarios
	task automatic t_reset();
		rd(`PWMCC_IMR_OFS);
		chk(rv, 32'h0, "mask reset");
		rd(ca(0, `PWMCC_DUTY_VALUE_SUB));
		chk(rv, 32'h0, "duty reset");
		rd(12'h100);
		chk(32'(rr), 32'h2, "unmapped resp");
	endtask : t_reset
	task automatic t_mask();
		wr(`PWMCC_IER_OFS, 32'hF);
		rd(`PWMCC_IMR_OFS);
		chk(rv, 32'hF, "enable all");
		wr(`PWMCC_IDR_OFS, 32'h5);
		rd(`PWMCC_IMR_OFS);
		chk(rv, 32'hA, "disable some");
		wr(`PWMCC_IDR_OFS, 32'h0);
		rd(`PWMCC_IMR_OFS);
		chk(rv, 32'hA, "disable none");
		wr(`PWMCC_IDR_OFS, 32'hF);
		rd(`PWMCC_IMR_OFS);
		chk(rv, 32'h0, "disable all");
	endtask : t_mask
	task automatic t_status();
		wr(`PWMCC_IER_OFS, 32'h2);
		cfg(0, 32'h0, 32'h1, 32'h4);
		repeat (20) @(posedge aclk);
		chk(32'(irq), 32'h0, "masked irq");
		rd(`PWMCC_ISR_OFS);
		chk(rv & 32'h1, 32'h1, "period flag");
		wr(`PWMCC_IER_OFS, 32'h1);
		repeat (20) @(posedge aclk);
		chk(32'(irq), 32'h1, "irq");
		wr(12'h008, 32'hF);
		rd(`PWMCC_ISR_OFS);
		rd(`PWMCC_ISR_OFS);
		chk(rv, 32'h0, "flags cleared");
		chk(32'(irq), 32'h0, "irq cleared");
	endtask : t_status
	task automatic t_clocks();
		for (int c = 0; c <= 10; c++) run(32'h0, 4'(c), 1 << c);
		run(32'h0105_0003, 4'hB, 3);
		run(32'h0105_0003, 4'hC, 10);
		run(32'h0000_0201, 4'hB, 4);
		wr(`PWMCC_MODE_OFS, 32'h0);
		cfg(1, 32'hB, 32'h1, 32'h2);
		hold(1, 1'b0);
	endtask : t_clocks
	task automatic t_shape();
		cfg(1, 32'h100, 32'h1, 32'h3);
		meas(1);
		chk(32'(per), 32'h6, "center period");
		chk(32'(hi), 32'h5, "center high");
		cfg(3, 32'h200, 32'h4, 32'h4);
		hold(3, 1'b1);
		cfg(3, 32'h0, 32'h0, 32'h4);
		hold(3, 1'b1);
		cfg(3, 32'h0, 32'h4, 32'h4);
		hold(3, 1'b0);
	endtask : t_shape
	task automatic t_update();
		cfg(2, 32'h0, 32'hABCD_0001, 32'h4);
		meas(2);
		chk(32'(hi), 32'h3, "low duty bits");
		wr(ca(2, `PWMCC_CUPD_SUB), 32'h3);
		meas(2);
		chk(32'(hi), 32'h1, "duty update");
		wr(ca(2, `PWMCC_CMR_SUB), 32'h400);
		wr(ca(2, `PWMCC_CUPD_SUB), 32'h8);
		meas(2);
		chk(32'(per), 32'h8, "period update");
		chk(32'(hi), 32'h5, "duty kept");
	endtask : t_update
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	initial begin
		repeat (100000) @(posedge aclk);
		n_errors++;
		finish_test();
	end
	initial begin
		n_errors = 0;
		samples_checked = 0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_mask();
		t_status();
		t_clocks();
		t_shape();
		t_update();
		finish_test();
	end
endmodule : pwmcc_top_tb
`default_nettype wire
